// ==== shared/itde_pkg.sv ====
// Constants and carrier types of the isochronous descriptor engine.
package itde_pkg;

    // ************************************************************
    // Register map and fields.
    // ************************************************************
    localparam logic [7:0] REG_CTRL    = 8'h00;
    localparam logic [7:0] REG_DESC_LO = 8'h04;
    localparam logic [7:0] REG_DESC_HI = 8'h08;
    localparam logic [7:0] REG_QH_CFG  = 8'h0C;
    localparam logic [7:0] REG_STATUS  = 8'h10;
    localparam logic [7:0] REG_MOVED   = 8'h14;
    localparam int CTRL_START    = 0;
    localparam int QH_TYPE_LO    = 0;
    localparam int QH_DIR_IN     = 3;
    localparam int QH_INACT      = 4;
    localparam int ST_BUSY       = 0;
    localparam int ST_TYPE_ERR   = 1;
    localparam int ST_BYTE_LO    = 8;
    localparam logic [2:0] TYPE_ISO  = 3'h1;
    localparam logic [4:0] QH_RESET  = 5'h01;

    // ************************************************************
    // Descriptor and segment layout.
    // ************************************************************
    localparam int DESC_WORDS    = 6;
    localparam int SEG_WORDS     = 2;
    localparam int STS_HI        = 31;
    localparam int STS_LO        = 24;
    localparam int CNT_HI        = 23;
    localparam int CNT_LO        = 16;
    localparam int PT_HI         = 15;
    localparam int B_ACTIVE      = 7;
    localparam int B_BUF_ERR     = 5;
    localparam int B_BABBLE      = 4;
    localparam int B_INACT       = 1;
    localparam int TOK_SMALL     = 0;
    localparam int TOK_IOC       = 1;
    localparam int OFS_HI        = 11;
    localparam int LEN_HI        = 15;
    localparam logic [20:0] MAX_BYTES = 21'h100000;
    localparam logic [63:0] SEG_PTR_MASK = 64'hFFFFFFFFFFFFFFFC;

    // ************************************************************
    // Carrier types.
    // ************************************************************
    typedef struct packed {
        logic        valid;
        logic        we;
        logic [63:0] addr;
        logic [31:0] wdata;
    } itde_mem_req_t;

    typedef struct packed {
        logic        start;
        logic        dir_in;
        logic [63:0] addr;
        logic [15:0] len;
    } itde_link_req_t;

    typedef struct packed {
        logic        done;
        logic [16:0] rx_len;
        logic        pkt_babble;
        logic        overrun;
        logic        underrun;
    } itde_link_rsp_t;

endpackage

// ==== src/itde_engine.sv ====
// Isochronous transfer descriptor engine: fetch, execute and retire.
//
// Design decisions made here: strobed register access and the register addresses.
`timescale 1ns/100ps

module itde_engine (
    input  wire logic                     clk_sys,
    input  wire logic                     rst,
    input  wire logic [7:0]               reg_addr,
    input  wire logic [31:0]              reg_wdata,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    output logic      [31:0]              reg_rdata,
    output itde_pkg::itde_mem_req_t       mem_req,
    input  wire logic                     mem_ack,
    input  wire logic [31:0]              mem_rdata,
    output itde_pkg::itde_link_req_t      link_req,
    input  wire itde_pkg::itde_link_rsp_t link_rsp,
    input  wire logic [16:0]              chan_time,
    output logic                          force_timeout,
    output logic                          complete_ioc
);

    // ************************************************************
    // Types, state and storage.
    // ************************************************************
    typedef enum logic [2:0] {
        S_IDLE, S_DESC_RD, S_SEG_RD, S_PL_RD,
        S_LINK, S_SEG_WB, S_NEXT, S_RETIRE
    } itde_state_t;

    itde_state_t  state_ff;
    logic [31:0]  desc_ff [itde_pkg::DESC_WORDS];
    logic [31:0]  seg_ff [itde_pkg::SEG_WORDS];
    logic [31:0]  pl_lo_ff;
    logic [2:0]   word_ff;
    logic [7:0]   seg_idx_ff;
    logic [7:0]   sts_ff;
    logic         retire_ff;
    logic         launched_ff;
    logic [20:0]  moved_ff;
    logic [63:0]  desc_base_ff;
    logic [4:0]   qh_cfg_ff;
    logic         start_ff;
    logic         type_err_ff;
    itde_pkg::itde_mem_req_t  mem_ff;
    itde_pkg::itde_link_req_t link_ff;
    logic         timeout_ff;
    logic         ioc_ff;
    logic [31:0]  rdata_ff;

    logic [63:0]  plp;
    logic [63:0]  slp;
    logic [7:0]   seg_cnt;
    logic [63:0]  seg_base;
    logic [16:0]  rx_len;

    // Address of one word of a table entry of 8 bytes.
    function automatic logic [63:0] entry_addr(
        input logic [63:0] base,
        input logic [7:0]  idx,
        input logic        word
    );
        entry_addr = base + {53'h0, idx, word, 2'h0};
    endfunction

    // True when the channel time has passed the presentation time.
    function automatic logic is_late(
        input logic [16:0] now,
        input logic [15:0] pt
    );
        logic [15:0] d;
        d = now[15:0] - pt;
        is_late = (d != 16'h0000) && !d[15];
    endfunction

    // Descriptor fields in their documented positions.
    assign plp      = {desc_ff[3], desc_ff[2]};
    assign slp      = {desc_ff[5], desc_ff[4]}
        & itde_pkg::SEG_PTR_MASK;
    assign seg_cnt  = desc_ff[0][itde_pkg::CNT_HI:itde_pkg::CNT_LO];
    assign seg_base = entry_addr(slp, seg_idx_ff, 1'b0);
    assign rx_len   = link_rsp.rx_len;

    // ************************************************************
    // Register writes.
    // ************************************************************

    // Software loads the descriptor address and queue configuration.
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            desc_base_ff <= 64'h0000000000000000;
            qh_cfg_ff    <= itde_pkg::QH_RESET;
        end
        else if (reg_wr && state_ff == S_IDLE)
        begin
            unique case (reg_addr)
                itde_pkg::REG_DESC_LO: desc_base_ff[31:0]  <= reg_wdata;
                itde_pkg::REG_DESC_HI: desc_base_ff[63:32] <= reg_wdata;
                itde_pkg::REG_QH_CFG:  qh_cfg_ff <= reg_wdata[4:0];
                default: ;
            endcase
        end
    end

    // A start is accepted only when the queue type is isochronous.
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            start_ff    <= 1'b0;
            type_err_ff <= 1'b0;
        end
        else
        begin
            start_ff <= 1'b0;
            if (reg_wr && reg_addr == itde_pkg::REG_CTRL
                && reg_wdata[itde_pkg::CTRL_START] && state_ff == S_IDLE)
            begin
                if (qh_cfg_ff[2:0] == itde_pkg::TYPE_ISO)
                begin
                    start_ff    <= 1'b1;
                    type_err_ff <= 1'b0;
                end
                else
                begin
                    type_err_ff <= 1'b1;
                end
            end
        end
    end

    // ************************************************************
    // Register reads.
    // ************************************************************

    // Read data stand in the cycle after the read strobe.
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            rdata_ff <= 32'h00000000;
        end
        else if (reg_rd)
        begin
            unique case (reg_addr)
                itde_pkg::REG_DESC_LO: rdata_ff <= desc_base_ff[31:0];
                itde_pkg::REG_DESC_HI: rdata_ff <= desc_base_ff[63:32];
                itde_pkg::REG_QH_CFG:  rdata_ff <= {27'h0, qh_cfg_ff};
                itde_pkg::REG_STATUS:
                    rdata_ff <= {16'h0, sts_ff, 6'h0, type_err_ff,
                                 state_ff != S_IDLE};
                itde_pkg::REG_MOVED:   rdata_ff <= {11'h0, moved_ff};
                default:               rdata_ff <= 32'h00000000;
            endcase
        end
        else
        begin
            rdata_ff <= 32'h00000000;
        end
    end

    // ************************************************************
    // Descriptor sequencer.
    // ************************************************************

    // Walks the descriptor, its segments and its page list in order.
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            state_ff    <= S_IDLE;
            word_ff     <= 3'h0;
            seg_idx_ff  <= 8'h00;
            sts_ff      <= 8'h00;
            retire_ff   <= 1'b0;
            launched_ff <= 1'b0;
            moved_ff    <= 21'h000000;
            pl_lo_ff    <= 32'h00000000;
            mem_ff      <= '0;
            link_ff     <= '0;
            timeout_ff  <= 1'b0;
            ioc_ff      <= 1'b0;
            for (int i = 0; i < itde_pkg::DESC_WORDS; i++)
            begin
                desc_ff[i] <= 32'h00000000;
            end
            seg_ff[0] <= 32'h00000000;
            seg_ff[1] <= 32'h00000000;
        end
        else
        begin
            link_ff.start <= 1'b0;
            timeout_ff    <= 1'b0;
            ioc_ff        <= 1'b0;
            if (mem_ack)
            begin
                mem_ff.valid <= 1'b0; // Request ends on its acknowledge.
            end
            unique case (state_ff)
                S_IDLE:
                begin
                    word_ff <= 3'h0;
                    if (start_ff)
                    begin
                        moved_ff <= 21'h000000;
                        state_ff <= S_DESC_RD;
                    end
                end
                S_DESC_RD:
                begin
                    if (!mem_ff.valid)
                    begin
                        mem_ff <= '{1'b1, 1'b0,
                                    desc_base_ff + {59'h0, word_ff, 2'h0},
                                    32'h00000000};
                    end
                    else if (mem_ack)
                    begin
                        desc_ff[word_ff] <= mem_rdata;
                        word_ff <= word_ff + 3'h1;
                        if (word_ff == 3'(itde_pkg::DESC_WORDS - 1))
                        begin
                            sts_ff     <= desc_ff[0][itde_pkg::STS_HI:
                                                     itde_pkg::STS_LO];
                            seg_idx_ff <= 8'h00;
                            word_ff    <= 3'h0;
                            // An idle descriptor is left untouched.
                            if (!desc_ff[0][itde_pkg::STS_LO +
                                            itde_pkg::B_ACTIVE])
                            begin
                                state_ff <= S_IDLE;
                            end
                            else if (seg_cnt == 8'h00)
                            begin
                                state_ff <= S_RETIRE;
                            end
                            else
                            begin
                                state_ff <= S_SEG_RD;
                            end
                        end
                    end
                end
                S_SEG_RD:
                begin
                    if (!mem_ff.valid)
                    begin
                        mem_ff <= '{1'b1, 1'b0,
                                    entry_addr(slp, seg_idx_ff, word_ff[0]),
                                    32'h00000000};
                    end
                    else if (mem_ack)
                    begin
                        seg_ff[word_ff[0]] <= mem_rdata;
                        word_ff <= word_ff + 3'h1;
                        if (word_ff[0])
                        begin
                            word_ff <= 3'h0;
                            if (!seg_ff[0][itde_pkg::STS_LO +
                                           itde_pkg::B_ACTIVE])
                            begin
                                state_ff <= S_NEXT;
                            end
                            else if (qh_cfg_ff[itde_pkg::QH_INACT])
                            begin
                                sts_ff[itde_pkg::B_INACT] <= 1'b1;
                                state_ff <= S_RETIRE;
                            end
                            else if (!qh_cfg_ff[itde_pkg::QH_DIR_IN]
                                     && seg_idx_ff == 8'h00
                                     && is_late(chan_time,
                                            desc_ff[0][itde_pkg::PT_HI:0]))
                            begin
                                // A late first outbound segment is discarded.
                                seg_ff[0][itde_pkg::STS_LO +
                                    itde_pkg::B_ACTIVE] <= 1'b0;
                                state_ff <= S_SEG_WB;
                            end
                            else if (desc_ff[1][itde_pkg::TOK_SMALL])
                            begin
                                link_ff.addr <= plp + {52'h0,
                                    mem_rdata[itde_pkg::OFS_HI:0]};
                                state_ff <= S_LINK;
                            end
                            else
                            begin
                                state_ff <= S_PL_RD;
                            end
                        end
                    end
                end
                S_PL_RD:
                begin
                    if (!mem_ff.valid)
                    begin
                        mem_ff <= '{1'b1, 1'b0,
                                    entry_addr(plp,
                                        seg_ff[0][itde_pkg::CNT_HI:
                                                  itde_pkg::CNT_LO],
                                        word_ff[0]),
                                    32'h00000000};
                    end
                    else if (mem_ack)
                    begin
                        word_ff <= word_ff + 3'h1;
                        if (!word_ff[0])
                        begin
                            pl_lo_ff <= mem_rdata;
                        end
                        else
                        begin
                            word_ff      <= 3'h0;
                            link_ff.addr <= {mem_rdata, pl_lo_ff} +
                                {52'h0, seg_ff[1][itde_pkg::OFS_HI:0]};
                            state_ff     <= S_LINK;
                        end
                    end
                end
                S_LINK:
                begin
                    if (!launched_ff)
                    begin
                        launched_ff    <= 1'b1;
                        link_ff.start  <= 1'b1;
                        link_ff.dir_in <= qh_cfg_ff[itde_pkg::QH_DIR_IN];
                        link_ff.len    <= seg_ff[0][itde_pkg::LEN_HI:0];
                    end
                    else
                    begin
                        if (link_rsp.overrun || link_rsp.underrun)
                        begin
                            sts_ff[itde_pkg::B_BUF_ERR] <= 1'b1;
                        end
                        if (link_rsp.overrun)
                        begin
                            timeout_ff <= 1'b1;
                        end
                        if (link_rsp.pkt_babble)
                        begin
                            sts_ff[itde_pkg::B_BABBLE] <= 1'b1;
                            retire_ff <= 1'b1;
                        end
                        if (link_rsp.done || link_rsp.pkt_babble)
                        begin
                            launched_ff <= 1'b0;
                            seg_ff[0][itde_pkg::STS_LO +
                                      itde_pkg::B_ACTIVE] <= 1'b0;
                            if (qh_cfg_ff[itde_pkg::QH_DIR_IN])
                            begin
                                seg_ff[0][itde_pkg::LEN_HI:0] <=
                                    rx_len[15:0];
                                if (rx_len > {1'b0,
                                    seg_ff[0][itde_pkg::LEN_HI:0]})
                                begin
                                    seg_ff[0][itde_pkg::STS_LO +
                                      itde_pkg::B_BABBLE] <= 1'b1;
                                end
                                moved_ff <= moved_ff + {4'h0, rx_len};
                            end
                            else
                            begin
                                moved_ff <= moved_ff + {5'h0,
                                    seg_ff[0][itde_pkg::LEN_HI:0]};
                            end
                            state_ff <= S_SEG_WB;
                        end
                    end
                end
                S_SEG_WB:
                begin
                    // Only the segment's status and length word is rewritten.
                    if (!mem_ff.valid)
                    begin
                        mem_ff <= '{1'b1, 1'b1, seg_base, seg_ff[0]};
                    end
                    else if (mem_ack)
                    begin
                        state_ff <= retire_ff ? S_RETIRE : S_NEXT;
                    end
                end
                S_NEXT:
                begin
                    seg_idx_ff <= seg_idx_ff + 8'h01;
                    if (seg_idx_ff + 8'h01 == seg_cnt
                        || moved_ff >= itde_pkg::MAX_BYTES)
                    begin
                        state_ff <= S_RETIRE;
                    end
                    else
                    begin
                        state_ff <= S_SEG_RD;
                    end
                end
                S_RETIRE:
                begin
                    // The single descriptor write: word zero, active cleared.
                    if (!mem_ff.valid)
                    begin
                        mem_ff <= '{1'b1, 1'b1, desc_base_ff,
                            {sts_ff & 8'h7F,
                             desc_ff[0][itde_pkg::CNT_HI:0]}};
                    end
                    else if (mem_ack)
                    begin
                        // Page-list words stay as software wrote them.
                        retire_ff <= 1'b0;
                        sts_ff[itde_pkg::B_ACTIVE] <= 1'b0;
                        ioc_ff   <= desc_ff[1][itde_pkg::TOK_IOC];
                        state_ff <= S_IDLE;
                    end
                end
            endcase
        end
    end

    // ************************************************************
    // Outputs straight from flip-flops.
    // ************************************************************
    assign reg_rdata     = rdata_ff;
    assign mem_req       = mem_ff;
    assign link_req      = link_ff;
    assign force_timeout = timeout_ff;
    assign complete_ioc  = ioc_ff;

endmodule

// ==== tb/itde_mem_model.sv ====
// Memory model that answers the engine's bus requests.
`timescale 1ns/100ps
module itde_mem_model (
    input  wire logic                    clk_sys,
    input  wire itde_pkg::itde_mem_req_t mem_req,
    input  wire logic                    slow,
    output logic                         mem_ack,
    output logic [31:0]                  mem_rdata
);
    logic [31:0] mem [256];
    logic [1:0]  wait_ff = 2'h0;

    // Acks after zero or three waits; read data churn outside the ack.
    always @(posedge clk_sys)
    begin
        mem_ack <= 1'b0;
        mem_rdata <= ~mem_rdata;
        if (mem_req.valid && !mem_ack && wait_ff != 2'h0)
            wait_ff <= wait_ff - 2'h1;
        else if (mem_req.valid && !mem_ack)
        begin
            mem_ack <= 1'b1;
            wait_ff <= {slow, slow};
            if (mem_req.we)
                mem[mem_req.addr[9:2]] <= mem_req.wdata;
            else
                mem_rdata <= mem[mem_req.addr[9:2]];
        end
    end
endmodule

// ==== tb/itde_engine_assertions.sv ====
// Port checker for the isochronous descriptor engine.
`timescale 1ns/100ps
module itde_engine_assertions (
    input wire logic                     clk_sys,
    input wire logic                     rst,
    input wire logic                     reg_rd,
    input wire logic [31:0]              reg_rdata,
    input wire itde_pkg::itde_mem_req_t  mem_req,
    input wire logic                     mem_ack,
    input wire itde_pkg::itde_link_req_t link_req,
    input wire itde_pkg::itde_link_rsp_t link_rsp,
    input wire logic                     force_timeout,
    input wire logic                     complete_ioc
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Segment writeback is requested two edges after done.
    sequence s_seg_wb;
        ##2 (mem_req.valid && mem_req.we);
    endsequence
    property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 32'h0; endproperty
    property p_hold;
        mem_req.valid && !mem_ack |=> mem_req.valid && $stable(mem_req);
    endproperty
    property p_gap; mem_ack |=> !mem_req.valid; endproperty
    property p_start; link_req.start |=> !link_req.start; endproperty
    property p_ft_cause; force_timeout |-> $past(link_rsp.overrun); endproperty
    property p_ft_once;
        link_rsp.overrun ##1 force_timeout |=> !force_timeout;
    endproperty
    property p_ioc; complete_ioc |=> !complete_ioc; endproperty
    property p_seg_wb; link_rsp.done |-> s_seg_wb; endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data outside read cycle");
    a_hold: assert property (p_hold)
        else $error("memory request changed before ack");
    a_gap: assert property (p_gap) else $error("request not dropped");
    a_start: assert property (p_start)
        else $error("start longer than one cycle");
    a_ft_cause: assert property (p_ft_cause)
        else $error("timeout without overrun");
    a_ft_once: assert property (p_ft_once)
        else $error("timeout pulse too long");
    a_ioc: assert property (p_ioc)
        else $error("completion pulse too long");
    a_seg_wb: assert property (p_seg_wb)
        else $error("segment not written back");
endmodule

bind itde_engine itde_engine_assertions u_itde_engine_assertions (
    .clk_sys(clk_sys), .rst(rst), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .mem_req(mem_req), .mem_ack(mem_ack), .link_req(link_req),
    .link_rsp(link_rsp), .force_timeout(force_timeout),
    .complete_ioc(complete_ioc)
);

// ==== tb/itde_engine_test.sv ====
// Self-checking bench for the isochronous descriptor engine.
`timescale 1ns/100ps
module itde_engine_test;
    logic                     clk_sys = 1'b0;
    logic                     rst = 1'b1;
    logic [7:0]               reg_addr = 8'h00;
    logic [31:0]              reg_wdata = 32'h0, reg_rdata, rv, mem_rdata;
    logic                     reg_wr = 1'b0, reg_rd = 1'b0, slow = 1'b0;
    logic                     mem_ack, force_timeout, complete_ioc;
    itde_pkg::itde_mem_req_t  mem_req;
    itde_pkg::itde_link_req_t link_req;
    itde_pkg::itde_link_rsp_t link_rsp = '0;
    logic [16:0]              chan_time = 17'h0;
    int                       errors = 0, n_compared = 0, n_ioc = 0, n_st = 0;

    itde_engine u_itde_engine (.clk_sys(clk_sys), .rst(rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_req(mem_req),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata), .link_req(link_req),
        .link_rsp(link_rsp), .chan_time(chan_time),
        .force_timeout(force_timeout), .complete_ioc(complete_ioc));
    itde_mem_model u_itde_mem_model (.clk_sys(clk_sys), .mem_req(mem_req),
        .slow(slow), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

    // Clock and counters of completion and start pulses.
    always #20 clk_sys = ~clk_sys;
    always @(posedge clk_sys)
    begin
        n_ioc <= n_ioc + int'(complete_ioc === 1'b1);
        n_st <= n_st + int'(link_req.start === 1'b1);
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            errors++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic results;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic m(input logic [7:0] a, input logic [31:0] d);
        u_itde_mem_model.mem[a] = d;
    endtask
    function automatic logic [31:0] mw(input logic [7:0] a);
        mw = u_itde_mem_model.mem[a];
    endfunction
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 rv = reg_rdata;
    endtask
    // Polls busy; a hang is cut short and ends the run.
    task automatic idle;
        int i;
        for (i = 0; i < 300 && rv[0] !== 1'b0; i++)
            rd(itde_pkg::REG_STATUS);
        chk(64'(i == 300), 0);
        if (i == 300)
            results();
    endtask
    task automatic run(input logic [7:0] w, input logic [31:0] w0, tok,
                       input logic [31:0] plp, slp);
        m(w, w0);
        m(w + 8'h1, tok);
        m(w + 8'h2, plp);
        m(w + 8'h3, 32'h0);
        m(w + 8'h4, slp);
        m(w + 8'h5, 32'h0);
        wr(itde_pkg::REG_DESC_LO, {22'h0, w, 2'h0});
        wr(itde_pkg::REG_DESC_HI, 32'h0);
        wr(itde_pkg::REG_CTRL, 32'h1);
        rv = 32'h1;
    endtask
    // Awaits one segment start, checks it, then answers.
    task automatic lnk(input logic [63:0] a, input logic [15:0] len,
                       input logic din, d, input logic [16:0] rx,
                       input logic bab, ovr);
        int i;
        for (i = 0; i < 400 && link_req.start !== 1'b1; i++)
            @(posedge clk_sys) #1;
        chk(64'(i == 400), 0);
        if (i == 400)
            results();
        chk(link_req.addr, a);
        chk({link_req.len, link_req.dir_in}, {len, din});
        if (ovr)
        begin
            @(posedge clk_sys) link_rsp.overrun <= 1'b1;
            @(posedge clk_sys) link_rsp.overrun <= 1'b0;
            #1 chk(force_timeout, 1'b1);
        end
        @(posedge clk_sys) link_rsp <= '{d, rx, bab, 1'b0, 1'b0};
        @(posedge clk_sys) link_rsp <= '0;
    endtask

    task automatic t_regs;
        rd(itde_pkg::REG_QH_CFG);
        chk(rv, 64'(itde_pkg::QH_RESET));
        rd(8'h20);
        chk(rv, 0);
        wr(itde_pkg::REG_QH_CFG, 32'h2);
        wr(itde_pkg::REG_CTRL, 32'h1);
        rd(itde_pkg::REG_STATUS);
        chk(rv & 32'h3, 32'h2);
        $display("registers done");
    endtask
    task automatic t_in;
        wr(itde_pkg::REG_QH_CFG, 32'h9);
        m(8'h40, 32'h8001_0010);
        m(8'h41, 32'h123);
        m(8'h42, 32'h8000_0004);
        m(8'h43, 32'h40);
        m(8'h80, 32'h7000);
        m(8'h81, 32'h0);
        m(8'h82, 32'h5000);
        m(8'h83, 32'h0);
        run(8'h00, 32'h8002_0000, 32'h2, 32'h200, 32'h100);
        lnk(64'h5123, 16'h10, 1'b1, 1'b1, 17'h8, 1'b0, 1'b1);
        lnk(64'h7040, 16'h4, 1'b1, 1'b1, 17'h5, 1'b0, 1'b0);
        idle();
        chk(mw(8'h40) & 32'hFFFF, 32'h8);
        chk(mw(8'h42) & 32'h9000_FFFF, 32'h1000_0005);
        chk(mw(8'h00), 32'h2002_0000);
        chk(mw(8'h02), 32'h200);
        rd(itde_pkg::REG_STATUS);
        chk(rv & 32'hFF03, 32'h2000);
        chk(64'(n_ioc), 1);
        $display("inbound done");
    endtask
    task automatic t_inact;
        int k = n_st;
        wr(itde_pkg::REG_QH_CFG, 32'h11);
        m(8'h40, 32'h8000_0010);
        run(8'h10, 32'h8001_0000, 32'h0, 32'h200, 32'h100);
        idle();
        chk(mw(8'h10), 32'h0201_0000);
        chk(64'(n_st), 64'(k));
        $display("inactivate done");
    endtask
    task automatic t_small;
        slow <= 1'b1;
        chan_time <= 17'h1_0000;
        wr(itde_pkg::REG_QH_CFG, 32'h1);
        m(8'h60, 32'h8000_0020);
        m(8'h61, 32'h10);
        run(8'h20, 32'h8001_0005, 32'h1, 32'h3001, 32'h180);
        lnk(64'h3011, 16'h20, 1'b0, 1'b0, 17'h0, 1'b1, 1'b0);
        idle();
        chk(mw(8'h20), 32'h1001_0005);
        chk(64'(n_ioc), 1);
        $display("small done");
    endtask

    initial
    begin
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        t_regs();
        t_in();
        t_inact();
        t_small();
        results();
    end
endmodule
